/* File: logic/iss_consts.svh */
// Constants for the interrupt status byte block
// Summary of operation
// - Bit 5 shows the timer one interrupt flag.
// - Bit 4 shows the timer zero interrupt flag.
// - Bit 3 is set when line one is enabled and any enabled flag routed to line one is set.
// - Bit 2 is set when line zero is enabled and any enabled flag routed to line zero is set.
// - Bit 1 is the OR of all status interrupt register flags.
// - Bit 0 is the OR of all error interrupt register flags.
// - Bits 7 and 6 always read zero.
// - Reported value is captured only at the falling chip select edge.
// - Each frame starts with 24 status bits, this byte last.
`ifndef ISS_CONSTS_SVH
`define ISS_CONSTS_SVH
`define ISS_BIT_TIMER1 5
`define ISS_BIT_TIMER0 4
`define ISS_BIT_LINE1 3
`define ISS_BIT_LINE0 2
`define ISS_BIT_STATUS 1
`define ISS_BIT_ERROR 0
`define ISS_RESERVED_VAL 2'h0
`define ISS_STATUS_BITS 24
`define ISS_BYTE_RESET 8'h00
`define ISS_ZERO_BYTE 8'h00
`endif

/* File: logic/iss_pkg.sv */
// Types for the interrupt status byte block
package iss_pkg;
	typedef struct packed {
		logic timer_one_irq;
		logic timer_zero_irq;
		logic [31:0] status_irq_reg;
		logic [31:0] error_irq_reg;
		logic [31:0] status_irq_enable_set;
		logic [31:0] error_irq_enable_set;
		logic [31:0] status_irq_line_select;
		logic [31:0] error_irq_line_select;
		logic [1:0] irq_line_enables;
	} iss_irq_state_t;
	typedef struct packed {
		logic [7:0] byte0;
		logic [7:0] byte1;
	} iss_other_status_t;
endpackage

/* File: logic/iss_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module iss_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_r <= INIT;
			q <= INIT;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

/* File: logic/iss_top.sv */
// Interrupt status byte generation and serial status shift-out
`timescale 1ns/100ps
`include "iss_consts.svh"
module iss_top (
	input wire logic core_clk,
	input wire logic reset,
	input wire iss_pkg::iss_irq_state_t irq_state,
	input wire iss_pkg::iss_other_status_t other_status,
	input wire logic spi_clk,
	input wire logic chip_select_n,
	output logic serial_out,
	output logic serial_out_en,
	output logic [7:0] interrupt_summary_status,
	output logic frame_active
);
	logic [7:0] live_byte;
	logic [31:0] status_routed;
	logic [31:0] error_routed;
	logic line_one_irq;
	logic line_zero_irq;
	logic [23:0] live_word;
	logic [23:0] live_word_r;
	logic [23:0] word_sync;
	logic cs_n_sync;
	logic cs_n_prev_r;
	logic cs_fall;
	logic [23:0] frame_word_r;
	logic [23:0] shift_r;
	logic [4:0] bit_cnt_r;
	logic cs_n_link_r;

	// Enabled flags steered to each line by their select bit
	assign status_routed = irq_state.status_irq_reg & irq_state.status_irq_enable_set;
	assign error_routed = irq_state.error_irq_reg & irq_state.error_irq_enable_set;
	assign line_one_irq = irq_state.irq_line_enables[1] &
		(|(status_routed & irq_state.status_irq_line_select) |
		|(error_routed & irq_state.error_irq_line_select));
	assign line_zero_irq = irq_state.irq_line_enables[0] &
		(|(status_routed & ~irq_state.status_irq_line_select) |
		|(error_routed & ~irq_state.error_irq_line_select));

	always_comb
	begin
		live_byte = `ISS_ZERO_BYTE;
		live_byte[7:6] = `ISS_RESERVED_VAL;
		live_byte[`ISS_BIT_TIMER1] = irq_state.timer_one_irq;
		live_byte[`ISS_BIT_TIMER0] = irq_state.timer_zero_irq;
		live_byte[`ISS_BIT_LINE1] = line_one_irq;
		live_byte[`ISS_BIT_LINE0] = line_zero_irq;
		live_byte[`ISS_BIT_STATUS] = |irq_state.status_irq_reg;
		live_byte[`ISS_BIT_ERROR] = |irq_state.error_irq_reg;
	end

	// Byte 0 leads, this byte goes out last
	assign live_word = {other_status.byte0, other_status.byte1, live_byte};

	always_ff @(posedge core_clk)
	begin
		if (reset)
			live_word_r <= {`ISS_ZERO_BYTE, `ISS_ZERO_BYTE, `ISS_BYTE_RESET};
		else
			live_word_r <= live_word;
	end

	// Chip select into core domain for the visible register copy
	iss_sync #(.WIDTH(1), .INIT(1'b1)) u_cs_sync (
		.clk(core_clk),
		.rst(reset),
		.d(chip_select_n),
		.q(cs_n_sync)
	);

	always_ff @(posedge core_clk)
	begin
		if (reset)
			cs_n_prev_r <= 1'b1;
		else
			cs_n_prev_r <= cs_n_sync;
	end
	assign cs_fall = cs_n_prev_r & ~cs_n_sync;

	always_ff @(posedge core_clk)
	begin
		if (reset)
			interrupt_summary_status <= `ISS_BYTE_RESET;
		else if (cs_fall)
			interrupt_summary_status <= live_byte;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			frame_active <= 1'b0;
		else
			frame_active <= ~cs_n_sync;
	end

	// Word crosses quasi-statically; flags change slowly relative to frames,
	// a bit caught mid-change reads old or new value only per bit.
	iss_sync #(.WIDTH(24), .INIT(24'h000000)) u_word_sync (
		.clk(spi_clk),
		.rst(chip_select_n),
		.d(live_word_r),
		.q(word_sync)
	);

	// Link side: frame held in reset while chip select is high
	always_ff @(posedge spi_clk or posedge chip_select_n)
	begin
		if (chip_select_n)
			cs_n_link_r <= 1'b1;
		else
			cs_n_link_r <= 1'b0;
	end

	// Snapshot taken at the falling chip select edge, held all frame
	always_ff @(negedge chip_select_n or posedge reset)
	begin
		if (reset)
			frame_word_r <= 24'h000000;
		else
			frame_word_r <= live_word_r;
	end

	always_ff @(negedge spi_clk or posedge chip_select_n)
	begin
		if (chip_select_n)
		begin
			shift_r <= 24'h000000;
			bit_cnt_r <= 5'h00;
		end
		else if (bit_cnt_r == 5'h00)
		begin
			shift_r <= {frame_word_r[22:0], 1'b0};
			bit_cnt_r <= 5'h01;
		end
		else if (bit_cnt_r < 5'(`ISS_STATUS_BITS))
		begin
			shift_r <= {shift_r[22:0], 1'b0};
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	always_comb
	begin
		if (chip_select_n)
			serial_out = 1'b0;
		else if (bit_cnt_r == 5'h00)
			serial_out = frame_word_r[23];
		else if (bit_cnt_r < 5'(`ISS_STATUS_BITS))
			serial_out = shift_r[23];
		else
			serial_out = 1'b0;
	end
	assign serial_out_en = ~chip_select_n;

	logic unused_ok;
	assign unused_ok = ^word_sync ^ cs_n_link_r;
endmodule

/* File: verification/iss_sva.sv */
// Port checker for the interrupt status byte block
`timescale 1ns/100ps
module iss_sva (
	input wire logic core_clk,
	input wire logic reset,
	input wire iss_pkg::iss_irq_state_t irq_state,
	input wire logic chip_select_n,
	input wire logic serial_out,
	input wire logic serial_out_en,
	input wire logic [7:0] interrupt_summary_status,
	input wire logic frame_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Capture settles within five core edges of the select edge
	sequence s_fall;
		$fell(chip_select_n) ##5 1'b1;
	endsequence
	a_rsvd_zero: assert property (interrupt_summary_status[7:6] == 2'h0)
		else $error("reserved bits set");
	a_reset_val: assert property ($past(reset) |-> !frame_active && interrupt_summary_status == 8'h00)
		else $error("bad reset value");
	a_frame_hold: assert property ($stable(chip_select_n) [*6] |=> $stable(interrupt_summary_status))
		else $error("byte moved without select edge");
	a_timer_one: assert property (s_fall |-> interrupt_summary_status[5] == $past(irq_state.timer_one_irq, 5))
		else $error("timer one bit");
	a_timer_zero: assert property (s_fall |-> interrupt_summary_status[4] == $past(irq_state.timer_zero_irq, 5))
		else $error("timer zero bit");
	a_status_or: assert property (s_fall |-> interrupt_summary_status[1] == $past(|irq_state.status_irq_reg, 5))
		else $error("status summary bit");
	a_error_or: assert property (s_fall |-> interrupt_summary_status[0] == $past(|irq_state.error_irq_reg, 5))
		else $error("error summary bit");
	a_out_enable: assert property (serial_out_en == !chip_select_n)
		else $error("enable not with select");
	a_out_idle: assert property (chip_select_n |-> !serial_out)
		else $error("output not low when idle");
endmodule

/* File: verification/iss_host.sv */
// Serial host master model reading one status frame
`timescale 1ns/100ps
module iss_host (
	output logic spi_clk,
	output logic chip_select_n,
	input wire logic serial_out
);
	initial
	begin
		spi_clk = 1'b0;
		chip_select_n = 1'b1;
	end
	// Clock stands still low outside frames
	task automatic frame(output logic [23:0] rx);
		#3 chip_select_n = 1'b0;
		repeat (24)
		begin
			#16 spi_clk = 1'b1;
			rx = {rx[22:0], serial_out};
			#16 spi_clk = 1'b0;
		end
		#16 chip_select_n = 1'b1;
	endtask
endmodule

/* File: verification/iss_top_tb.sv */
// Self-checking bench for the interrupt status byte block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED %0t mismatch", $time); end end
module iss_top_tb;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	iss_pkg::iss_irq_state_t irq_state = '0;
	iss_pkg::iss_other_status_t other_status = 16'h0000;
	logic spi_clk, chip_select_n, serial_out, serial_out_en, frame_active;
	logic [7:0] interrupt_summary_status;
	logic [23:0] rx;
	int error_cnt = 0;
	int checks = 0;
	always #5 core_clk = ~core_clk;
	iss_top iss_top_inst (.core_clk(core_clk), .reset(reset), .irq_state(irq_state),
		.other_status(other_status), .spi_clk(spi_clk), .chip_select_n(chip_select_n),
		.serial_out(serial_out), .serial_out_en(serial_out_en), .frame_active(frame_active),
		.interrupt_summary_status(interrupt_summary_status));
	iss_host iss_host_inst (.spi_clk(spi_clk), .chip_select_n(chip_select_n), .serial_out(serial_out));
	function automatic logic [7:0] exp_byte(iss_pkg::iss_irq_state_t s);
		logic [31:0] sa;
		logic [31:0] ea;
		sa = s.status_irq_reg & s.status_irq_enable_set;
		ea = s.error_irq_reg & s.error_irq_enable_set;
		return {2'h0, s.timer_one_irq, s.timer_zero_irq,
			s.irq_line_enables[1] & |(sa & s.status_irq_line_select | ea & s.error_irq_line_select),
			s.irq_line_enables[0] & |(sa & ~s.status_irq_line_select | ea & ~s.error_irq_line_select),
			|s.status_irq_reg, |s.error_irq_reg};
	endfunction
	task automatic sweep;
		iss_pkg::iss_irq_state_t s;
		for (int i = 0; i < 16; i++)
		begin
			s = {i[0], i[1], {i[2], 31'h0}, {31'h0, i[3]}, {32{i[0]}}, {32{i[1]}}, {32{i[1]}},
				{32{i[2]}}, ~i[3], 1'b1};
			@(posedge core_clk);
			irq_state <= s;
			other_status <= {4{i[3:0]}};
			repeat (3) @(posedge core_clk);
			iss_host_inst.frame(rx);
			`CHK(rx, {other_status, exp_byte(s)})
			repeat (6) @(posedge core_clk);
			`CHK(interrupt_summary_status, exp_byte(s))
		end
	endtask
	task automatic mid_frame;
		iss_pkg::iss_irq_state_t a;
		a = {2'h3, 32'h0000_0010, 32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0, 2'h1};
		@(posedge core_clk);
		irq_state <= a;
		repeat (3) @(posedge core_clk);
		fork
			iss_host_inst.frame(rx);
			begin
				repeat (20) @(posedge core_clk);
				`CHK(frame_active, 1'b1)
				irq_state <= '0;
			end
		join
		`CHK(rx[7:0], exp_byte(a))
		repeat (6) @(posedge core_clk);
		`CHK(interrupt_summary_status, exp_byte(a))
		iss_host_inst.frame(rx);
		`CHK(rx[7:0], 8'h00)
	endtask
	task automatic test_done;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1 `CHK(interrupt_summary_status, 8'h00)
		`CHK(frame_active, 1'b0)
		repeat (3) @(posedge core_clk);
		sweep();
		mid_frame();
		test_done();
	end
	initial
	begin
		#100000;
		error_cnt++;
		test_done();
	end
endmodule
bind iss_top iss_sva iss_sva_inst (.core_clk(core_clk), .reset(reset), .irq_state(irq_state),
	.chip_select_n(chip_select_n), .serial_out(serial_out), .serial_out_en(serial_out_en),
	.interrupt_summary_status(interrupt_summary_status), .frame_active(frame_active));
